// File: src/imufic_pkg.sv
/*
 Constants for the sample-buffer and interrupt-routing block.
 Assumes a classic Wishbone slave with 8-bit registers in the low byte of
 32-bit words; byte address is four times the register index.
*/
package imufic_pkg;
   // Register indices
   localparam logic [7:0] IDX_STAT0   = 8'h10;
   localparam logic [7:0] IDX_STAT1   = 8'h11;
   localparam logic [7:0] IDX_STAT2   = 8'h12;
   localparam logic [7:0] IDX_FMODE   = 8'h35;
   localparam logic [7:0] IDX_WM_LO   = 8'h36;
   localparam logic [7:0] IDX_WM_HI   = 8'h37;
   localparam logic [7:0] IDX_DECIM   = 8'h39;
   localparam logic [7:0] IDX_EN0     = 8'h40;
   localparam logic [7:0] IDX_EN1     = 8'h41;
   localparam logic [7:0] IDX_ICFG    = 8'h44;
   localparam logic [7:0] IDX_HOLD    = 8'h45;
   localparam logic [7:0] IDX_PIN0    = 8'h79;
   localparam logic [7:0] IDX_PIN1    = 8'h7A;
   localparam logic [7:0] IDX_FDATA   = 8'h60;
   localparam logic [7:0] IDX_FCNT_LO = 8'h61;
   localparam logic [7:0] IDX_FCNT_HI = 8'h62;
   // Configuration fields
   localparam int ICFG_POL   = 7;
   localparam int ICFG_NLAT  = 6;
   localparam int ICFG_ANYRD = 4;
   localparam int ICFG_OD_B  = 2;
   localparam int ICFG_OD_A  = 0;
   // Buffer modes
   localparam logic [1:0] FM_OFF    = 2'b00;
   localparam logic [1:0] FM_FILL   = 2'b01;
   localparam logic [1:0] FM_STREAM = 2'b10;
   localparam logic [1:0] FM_TRIG   = 2'b11;
   // Sizes
   localparam int NSRC      = 13;
   localparam int FIFO_WORDS = 1024;
   localparam int CNT_W     = 11;
   // Source indices
   localparam int S_INACT = 0;
   localparam int S_ACT   = 1;
   localparam int S_DTAP  = 2;
   localparam int S_STAP  = 3;
   localparam int S_TAP   = 4;
   localparam int S_FLAT  = 5;
   localparam int S_ORNT  = 6;
   localparam int S_FFALL = 7;
   localparam int S_WM    = 8;
   localparam int S_GRDY  = 9;
   localparam int S_ARDY  = 10;
   localparam int S_LOWG  = 11;
   localparam int S_HIGHG = 12;
   // Timing
   localparam int CLK_HZ       = 25_000_000;
   localparam int RDY_CLR_NS   = 200;
   localparam int RDY_CLR_CYC  = (RDY_CLR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int HOLD_UNIT_NS = 1000;
   localparam int HOLD_UNIT_CYC = (HOLD_UNIT_NS * (CLK_HZ / 1_000_000)) / 1000;
endpackage : imufic_pkg

// File: src/imufic_top.sv
/*
 Sample-buffer control and two-pin interrupt routing for a six-axis sensor.
 Assumes a classic Wishbone master on ref_clk; event and sample inputs are
 one-cycle pulses from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module imufic_top
   import imufic_pkg::*;
#(
   parameter int DEPTH = imufic_pkg::FIFO_WORDS,
   parameter int AW    = 10
)(
   input  wire logic                    ref_clk,    // System clock
   input  wire logic                    nrst,       // Async reset, low
   input  wire logic                    wb_cyc_i,   // Wishbone cycle
   input  wire logic                    wb_stb_i,   // Wishbone strobe
   input  wire logic                    wb_we_i,    // Wishbone write
   input  wire logic [9:0]              wb_adr_i,   // Byte address
   input  wire logic [3:0]              wb_sel_i,   // Byte enables
   input  wire logic [31:0]             wb_dat_i,   // Write data
   output logic      [31:0]             wb_dat_o,   // Read data
   output logic                         wb_ack_o,   // Acknowledge
   input  wire logic [imufic_pkg::NSRC-1:0] src_evt,  // Source event pulses
   input  wire logic                    smp_valid,  // Sample byte valid
   input  wire logic                    smp_is_imu, // Sample is gyro/accel
   input  wire logic [7:0]              smp_data,   // Sample byte
   output logic                         irq_out_a,  // First pin level
   output logic                         irq_out_a_oe, // First pin enable
   output logic                         irq_out_b,  // Second pin level
   output logic                         irq_out_b_oe  // Second pin enable
);
   import imufic_pkg::*;

   logic [7:0] fmode, wm_lo, wm_hi, decim, en0, en1, icfg, hold, pin0, pin1;
   logic [7:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr;
   logic [CNT_W-1:0] count;
   logic [7:0] dec_cnt;
   logic frozen;
   logic [NSRC-1:0] flag, src_en, src_route;
   logic [NSRC-1:0] rdy_mask;
   logic [15:0] nl_cnt [NSRC];
   logic [7:0] next_rdata;

   wire logic [7:0] idx = wb_adr_i[9:2];
   wire logic       req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire logic       wr  = req & wb_we_i & wb_sel_i[0];
   wire logic       rd  = req & ~wb_we_i;
   wire logic [CNT_W-1:0] wm_lvl = {wm_hi[2:0], wm_lo};
   wire logic       full  = (count == CNT_W'(DEPTH));
   wire logic       empty = (count == '0);

   function automatic logic is_stat(input logic [7:0] a);
      return (a == IDX_STAT0) || (a == IDX_STAT1) || (a == IDX_STAT2);
   endfunction

   // Wishbone answer one cycle after the request is seen
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= {24'h00_0000, next_rdata};
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fmode <= 8'h00;
         wm_lo <= 8'h00;
         wm_hi <= 8'h00;
         decim <= 8'h00;
         en0   <= 8'h00;
         en1   <= 8'h00;
         icfg  <= 8'h00;
         hold  <= 8'h01;
         pin0  <= 8'h00;
         pin1  <= 8'h00;
      end else if (wr) begin
         case (idx)
            IDX_FMODE: fmode <= {6'h00, wb_dat_i[1:0]};
            IDX_WM_LO: wm_lo <= wb_dat_i[7:0];
            IDX_WM_HI: wm_hi <= {5'h00, wb_dat_i[2:0]};
            IDX_DECIM: decim <= wb_dat_i[7:0];
            IDX_EN0:   en0   <= wb_dat_i[7:0];
            IDX_EN1:   en1   <= wb_dat_i[7:0];
            IDX_ICFG:  icfg  <= wb_dat_i[7:0];
            IDX_HOLD:  hold  <= wb_dat_i[7:0];
            IDX_PIN0:  pin0  <= wb_dat_i[7:0];
            IDX_PIN1:  pin1  <= wb_dat_i[7:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      src_en = '0;
      src_route = '0;
      src_en[S_INACT]    = en0[5];
      src_route[S_INACT] = pin0[6];
      src_en[S_ACT]      = en0[4];
      src_route[S_ACT]   = pin0[5];
      src_en[S_DTAP]     = en0[3];
      src_route[S_DTAP]  = pin0[3];
      src_en[S_STAP]     = en0[2];
      src_route[S_STAP]  = pin0[2];
      // Either tap enable arms the combined tap source
      src_en[S_TAP]      = en0[2] | en0[3];
      src_route[S_TAP]   = pin0[4];
      src_en[S_FLAT]     = en0[1];
      src_route[S_FLAT]  = pin0[1];
      src_en[S_ORNT]     = en0[0];
      src_route[S_ORNT]  = pin0[0];
      src_en[S_FFALL]    = en1[0];
      src_route[S_FFALL] = pin1[1];
      src_en[S_WM]       = en1[4];
      src_route[S_WM]    = pin1[5];
      src_en[S_GRDY]     = en1[3];
      src_route[S_GRDY]  = pin1[4];
      src_en[S_ARDY]     = en1[1];
      src_route[S_ARDY]  = pin1[2];
      src_en[S_LOWG]     = en0[7];
      src_route[S_LOWG]  = pin1[0];
      src_en[S_HIGHG]    = en0[6];
      src_route[S_HIGHG] = pin0[7];
      rdy_mask = '0;
      rdy_mask[S_GRDY] = 1'b1;
      rdy_mask[S_ARDY] = 1'b1;
   end

   // Decimation: keep one in (decim+1) gyro/accel bytes
   wire logic dec_keep = ~smp_is_imu | (dec_cnt == decim);
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dec_cnt <= 8'h00;
      end else if (smp_valid && smp_is_imu) begin
         dec_cnt <= (dec_cnt == decim) ? 8'h00 : dec_cnt + 8'h01;
      end
   end

   // Trigger from any enabled non-watermark source
   logic [NSRC-1:0] trig_mask;
   always_comb begin
      trig_mask = src_en & src_evt;
      trig_mask[S_WM] = 1'b0;
   end
   wire logic trig_evt = |trig_mask;

   // Sample buffer pointer and count logic
   wire logic rd_data = rd && (idx == IDX_FDATA) && !empty;
   wire logic s_in    = smp_valid && dec_keep && (fmode != FM_OFF);
   // Streaming discards oldest on a full buffer
   wire logic drop    = s_in && full && !rd_data &&
                        ((fmode == FM_STREAM) || (fmode == FM_TRIG && !frozen));
   wire logic push    = s_in && (!full || drop || rd_data);
   wire logic pop     = rd_data || drop;
   logic trim;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         frozen <= 1'b0;
      end else if (fmode != FM_TRIG) begin
         frozen <= 1'b0;
      end else if (trig_evt) begin
         frozen <= 1'b1;
      end
   end
   // On freeze keep only the newest watermark-count samples
   assign trim = (fmode == FM_TRIG) && !frozen && trig_evt && (count > wm_lvl);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      // Disabled mode flushes and stays empty
      end else if (fmode == FM_OFF) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (trim) begin
         // A sample landing on the trigger edge counts as the newest one
         rd_ptr <= wr_ptr + AW'(push) - AW'(wm_lvl);
         count  <= wm_lvl;
         if (push) wr_ptr <= wr_ptr + 1'b1;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         count <= count + CNT_W'(push) - CNT_W'(pop);
      end
   end

   // Storage written at the write pointer
   always_ff @(posedge ref_clk) begin
      if (push && fmode != FM_OFF) mem[wr_ptr] <= smp_data;
   end

   wire logic wm_evt = (fmode != FM_OFF) && (count >= wm_lvl) && (wm_lvl != '0);
   logic [NSRC-1:0] evt;
   always_comb begin
      evt = src_evt;
      evt[S_WM] = wm_evt;
   end

   wire logic clr_rd = rd && (icfg[ICFG_ANYRD] || is_stat(idx));

   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_src
         always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               flag[g] <= 1'b0;
               nl_cnt[g] <= 16'h0000;
            end else if (!src_en[g]) begin
               flag[g] <= 1'b0;
               nl_cnt[g] <= 16'h0000;
            end else if (evt[g]) begin
               // Set beats a read or countdown clear in the same cycle
               flag[g] <= 1'b1;
               nl_cnt[g] <= rdy_mask[g] ? 16'(RDY_CLR_CYC) :
                            16'(hold) * 16'(HOLD_UNIT_CYC);
            end else if (rdy_mask[g] || icfg[ICFG_NLAT]) begin
               if (nl_cnt[g] <= 16'h0001) begin
                  flag[g] <= 1'b0;
                  nl_cnt[g] <= 16'h0000;
               end else begin
                  nl_cnt[g] <= nl_cnt[g] - 16'h0001;
               end
            // Latched flags clear on the selected read
            end else if (clr_rd) begin
               flag[g] <= 1'b0;
            end
         end
      end
   endgenerate

   always_comb begin
      next_rdata = 8'h00;
      case (idx)
         IDX_STAT0:   next_rdata = {flag[S_FFALL], flag[S_ORNT], flag[S_FLAT], flag[S_TAP],
                                    flag[S_STAP], flag[S_DTAP], flag[S_ACT], flag[S_INACT]};
         IDX_STAT1:   next_rdata = {4'h0, flag[S_ARDY], 1'b0, flag[S_GRDY], flag[S_WM]};
         IDX_STAT2:   next_rdata = {{4{flag[S_HIGHG]}}, 3'b000, flag[S_LOWG]};
         IDX_FMODE:   next_rdata = fmode;
         IDX_WM_LO:   next_rdata = wm_lo;
         IDX_WM_HI:   next_rdata = wm_hi;
         IDX_DECIM:   next_rdata = decim;
         IDX_EN0:     next_rdata = en0;
         IDX_EN1:     next_rdata = en1;
         IDX_ICFG:    next_rdata = icfg;
         IDX_HOLD:    next_rdata = hold;
         IDX_PIN0:    next_rdata = pin0;
         IDX_PIN1:    next_rdata = pin1;
         IDX_FDATA:   next_rdata = empty ? 8'h00 : mem[rd_ptr];
         IDX_FCNT_LO: next_rdata = count[7:0];
         IDX_FCNT_HI: next_rdata = {5'h00, count[CNT_W-1:8]};
         default:     next_rdata = 8'h00;
      endcase
   end

   wire logic act_a = |(flag & ~src_route);
   wire logic act_b = |(flag & src_route);

   // Shared polarity, drive type per pin
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         irq_out_a <= 1'b0;
         irq_out_a_oe <= 1'b1;
         irq_out_b <= 1'b0;
         irq_out_b_oe <= 1'b1;
      end else begin
         irq_out_a <= act_a ^ icfg[ICFG_POL];
         irq_out_b <= act_b ^ icfg[ICFG_POL];
         irq_out_a_oe <= ~icfg[ICFG_OD_A] | ~(act_a ^ icfg[ICFG_POL]);
         irq_out_b_oe <= ~icfg[ICFG_OD_B] | ~(act_b ^ icfg[ICFG_POL]);
      end
   end
endmodule // imufic_top
`default_nettype wire

// File: tb/imufic_host_pins.sv
/*
 Host side of the interrupt lines: pull-ups that resolve each line.
 Assumes the design's level and enable outputs feed it directly.
*/
`timescale 1ns/1ps
`default_nettype none
module imufic_host_pins (
   input  wire logic lvl_a,  // First pin level
   input  wire logic oe_a,   // First pin enable
   input  wire logic lvl_b,  // Second pin level
   input  wire logic oe_b,   // Second pin enable
   output logic      wire_a, // Resolved first line
   output logic      wire_b  // Resolved second line
);
   assign wire_a = oe_a ? lvl_a : 1'b1;
   assign wire_b = oe_b ? lvl_b : 1'b1;
endmodule // imufic_host_pins
`default_nettype wire

// File: tb/imufic_top_monitor.sv
/*
 Port checker for the buffer and interrupt block.
 Assumes classic Wishbone on ref_clk; config is shadowed from bus writes.
*/
`timescale 1ns/1ps
`default_nettype none
module imufic_top_monitor
   import imufic_pkg::*;
#(
   parameter int DEPTH = imufic_pkg::FIFO_WORDS
)(
   input wire logic        ref_clk,      // Clock
   input wire logic        nrst,         // Reset, low
   input wire logic        wb_cyc_i,     // Cycle
   input wire logic        wb_stb_i,     // Strobe
   input wire logic        wb_we_i,      // Write
   input wire logic [9:0]  wb_adr_i,     // Address
   input wire logic [3:0]  wb_sel_i,     // Byte enables
   input wire logic [31:0] wb_dat_i,     // Write data
   input wire logic [31:0] wb_dat_o,     // Read data
   input wire logic        wb_ack_o,     // Acknowledge
   input wire logic        irq_out_a,    // First pin
   input wire logic        irq_out_a_oe, // First enable
   input wire logic        irq_out_b,    // Second pin
   input wire logic        irq_out_b_oe  // Second enable
);
   import imufic_pkg::*;
   logic [7:0] cfg;
   logic [7:0] en0;
   logic [7:0] en1;
   logic [1:0] quiet;
   wire logic  wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cfg <= '0;
         en0 <= '0;
         en1 <= '0;
      end else if (wr) begin
         if (wb_adr_i[9:2] == IDX_ICFG) cfg <= wb_dat_i[7:0];
         if (wb_adr_i[9:2] == IDX_EN0) en0 <= wb_dat_i[7:0];
         if (wb_adr_i[9:2] == IDX_EN1) en1 <= wb_dat_i[7:0];
      end
   end
   // Pins lag a config write by a register stage or two
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) quiet <= '0;
      else if (wr) quiet <= '0;
      else if (quiet != 2'd3) quiet <= quiet + 2'd1;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_answer;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_answer: assert property (s_take |=> s_answer) else $error("ack not one cycle after take");
   a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[9:6] == 4'h0
      |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
   a_count_bound: assert property (wb_ack_o && !wb_we_i && wb_adr_i[9:2] == IDX_FCNT_HI
      |-> wb_dat_o[7:0] <= 8'(DEPTH >> 8)) else $error("count above depth");
   a_od_low_a: assert property (quiet[1] && cfg[ICFG_OD_A] && irq_out_a_oe |-> !irq_out_a)
      else $error("open drain drives high");
   a_pp_oe_b: assert property (quiet[1] && !cfg[ICFG_OD_B] |-> irq_out_b_oe)
      else $error("push pull not driven");
   a_od_low_b: assert property (quiet[1] && cfg[ICFG_OD_B] && irq_out_b_oe |-> !irq_out_b)
      else $error("open drain drives second pin high");
   a_count_lo_bound: assert property (wb_ack_o && !wb_we_i && wb_adr_i[9:2] == IDX_FCNT_LO
      && DEPTH < 256 |-> wb_dat_o[7:0] <= 8'(DEPTH)) else $error("low count above depth");
   a_idle_inactive: assert property (quiet == 2'd3 && en0 == 8'h00 && en1 == 8'h00
      |-> (irq_out_a_oe ? irq_out_a == cfg[ICFG_POL] : cfg[ICFG_OD_A] && cfg[ICFG_POL])
       && (irq_out_b_oe ? irq_out_b == cfg[ICFG_POL] : cfg[ICFG_OD_B] && cfg[ICFG_POL]))
      else $error("disabled sources drive a pin");
endmodule // imufic_top_monitor
bind imufic_top imufic_top_monitor #(.DEPTH(DEPTH)) i_imufic_top_monitor (
   .ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_out_a(irq_out_a),
   .irq_out_a_oe(irq_out_a_oe), .irq_out_b(irq_out_b), .irq_out_b_oe(irq_out_b_oe));
`default_nettype wire

// File: tb/imufic_top_test.sv
/*
 Self-checking bench: buffer modes, decimation and interrupt pins.
 Assumes an 8-entry buffer so the full cases run short.
*/
`timescale 1ns/1ps
`default_nettype none
module imufic_top_test;
   import imufic_pkg::*;
   localparam int D = 8;
   logic            ref_clk = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic            wb_we_i = 1'b0, wb_ack_o, smp_valid = 1'b0, smp_is_imu = 1'b0;
   logic [9:0]      wb_adr_i = '0;
   logic [3:0]      wb_sel_i = '0;
   logic [31:0]     wb_dat_i = '0, wb_dat_o, seed = 32'h0000_8bd6;
   logic [7:0]      smp_data = '0, rd, hi, q[$];
   logic [10:0]     c;
   logic [NSRC-1:0] src_evt = '0;
   logic            irq_out_a, irq_out_a_oe, irq_out_b, irq_out_b_oe, pin_a, pin_b;
   int              n_mismatch = 0, n_checks = 0;
   imufic_top #(.DEPTH(D), .AW(3)) i_imufic_top (.ref_clk(ref_clk), .nrst(nrst),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .src_evt(src_evt), .smp_valid(smp_valid), .smp_is_imu(smp_is_imu), .smp_data(smp_data),
      .irq_out_a(irq_out_a), .irq_out_a_oe(irq_out_a_oe), .irq_out_b(irq_out_b),
      .irq_out_b_oe(irq_out_b_oe));
   imufic_host_pins i_imufic_host_pins (.lvl_a(irq_out_a), .oe_a(irq_out_a_oe),
      .lvl_b(irq_out_b), .oe_b(irq_out_b_oe), .wire_a(pin_a), .wire_b(pin_b));
   initial forever #20 ref_clk = ~ref_clk;
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
      int i;
      @(posedge ref_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'h1};
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h00_0000, d};
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 50);
      if (i >= 50) begin
         n_mismatch++;
         report_and_stop();
      end
      rd = wb_dat_o[7:0];
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   task automatic cnt;
      wb(0, IDX_FCNT_LO, 8'h00);
      hi = rd;
      wb(0, IDX_FCNT_HI, 8'h00);
      c = {rd[2:0], hi};
   endtask
   task automatic push(input logic imu, input int n);
      repeat (n) begin
         @(posedge ref_clk);
         seed = lfsr(seed);
         {smp_valid, smp_is_imu, smp_data} <= {1'b1, imu, seed[7:0]};
         q.push_back(seed[7:0]);
         @(posedge ref_clk);
         smp_valid <= 1'b0;
      end
   endtask
   task automatic pulse(input int s);
      @(posedge ref_clk);
      src_evt <= 13'h0001 << s;
      @(posedge ref_clk);
      src_evt <= '0;
      repeat (3) @(posedge ref_clk);
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      wb(0, IDX_HOLD, 8'h00);
      chk("hold reset", 11'd1, rd);
      wb(0, 8'h00, 8'h00);
      chk("unmapped", 11'd0, rd);
      wb(1, IDX_WM_LO, 8'h03);
      wb(1, IDX_EN1, 8'h10);
      wb(1, IDX_FMODE, FM_FILL);
      push(0, D + 2);
      cnt();
      chk("fill count", D, c);
      wb(0, IDX_STAT1, 8'h00);
      chk("watermark", 11'd1, rd[0]);
      wb(0, IDX_FDATA, 8'h00);
      chk("fill head", q[0], rd);
      wb(1, IDX_FMODE, FM_OFF);
      cnt();
      chk("flush", 11'd0, c);
      push(0, 1);
      cnt();
      chk("off empty", 11'd0, c);
      q = {};
      wb(1, IDX_FMODE, FM_STREAM);
      push(0, D + 3);
      cnt();
      chk("stream count", D, c);
      wb(0, IDX_FDATA, 8'h00);
      chk("stream head", q[3], rd);
      $display("buffer modes done");
      wb(1, IDX_FMODE, FM_OFF);
      wb(1, IDX_DECIM, 8'h01);
      wb(1, IDX_FMODE, FM_FILL);
      push(1, 4);
      cnt();
      chk("decimated count", 11'd2, c);
      wb(1, IDX_DECIM, 8'h00);
      wb(1, IDX_FMODE, FM_OFF);
      wb(1, IDX_WM_LO, 8'h02);
      wb(1, IDX_EN1, 8'h01);
      q = {};
      wb(1, IDX_FMODE, FM_TRIG);
      push(0, 5);
      pulse(S_FFALL);
      push(0, 3);
      cnt();
      chk("trigger count", 11'd5, c);
      wb(0, IDX_FDATA, 8'h00);
      chk("trigger head", q[3], rd);
      wb(1, IDX_FMODE, FM_OFF);
      wb(0, IDX_STAT0, 8'h00);
      $display("trigger and decimation done");
      wb(1, IDX_EN1, 8'h0b);
      wb(1, IDX_PIN1, 8'h10);
      pulse(S_GRDY);
      chk("gyro pin b", 11'd1, irq_out_b);
      chk("gyro not a", 11'd0, irq_out_a);
      repeat (RDY_CLR_CYC + 3) @(posedge ref_clk);
      chk("gyro cleared", 11'd0, irq_out_b);
      pulse(S_ARDY);
      chk("accel pin a", 11'd1, irq_out_a);
      repeat (RDY_CLR_CYC + 3) @(posedge ref_clk);
      pulse(S_FFALL);
      repeat (40) @(posedge ref_clk);
      chk("latched held", 11'd1, irq_out_a);
      wb(0, IDX_STAT0, 8'h00);
      chk("status bit", 11'd1, rd[7]);
      repeat (3) @(posedge ref_clk);
      chk("status clear", 11'd0, irq_out_a);
      wb(1, IDX_ICFG, 8'h10);
      pulse(S_FFALL);
      wb(0, IDX_HOLD, 8'h00);
      repeat (3) @(posedge ref_clk);
      chk("any read clear", 11'd0, irq_out_a);
      wb(1, IDX_ICFG, 8'h40);
      pulse(S_FFALL);
      repeat (10) @(posedge ref_clk);
      chk("nonlatched held", 11'd1, irq_out_a);
      repeat (25) @(posedge ref_clk);
      chk("nonlatched gone", 11'd0, irq_out_a);
      wb(1, IDX_ICFG, 8'h85);
      repeat (3) @(posedge ref_clk);
      chk("od idle line", 11'd1, pin_a);
      chk("od released b", 11'd0, irq_out_b_oe);
      pulse(S_FFALL);
      chk("od active line", 11'd0, pin_a);
      wb(0, IDX_STAT0, 8'h00);
      wb(1, IDX_EN1, 8'h00);
      wb(1, IDX_ICFG, 8'h00);
      repeat (20) begin
         @(posedge ref_clk);
         seed = lfsr(seed);
         src_evt <= seed[NSRC-1:0];
      end
      src_evt <= '0;
      repeat (3) @(posedge ref_clk);
      chk("disabled a", 11'd0, irq_out_a);
      chk("disabled b", 11'd0, irq_out_b);
      wb(1, IDX_EN0, 8'h40);
      wb(1, IDX_PIN0, 8'h80);
      pulse(S_HIGHG);
      chk("highg pin b", 11'd1, irq_out_b);
      wb(0, IDX_STAT2, 8'h00);
      chk("highg status", 11'h0f0, rd);
      $display("interrupt pins done");
      report_and_stop();
   end
endmodule // imufic_top_test
`default_nettype wire
